// ### core/webank_top.sv
`timescale 1ns/1ps
// global warning and error status bank
module webank_top
  import webank_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire webank_req_s req,
  output webank_rsp_s rsp,
  // raw condition pins
  input wire logic [15:0] warn_cond,
  input wire logic [15:0] err_cond,
  input wire logic ctrl_variant,
  // indicator and nonvolatile save
  output logic warn_led,
  output webank_nv_s nv_save
);

  ////////////////////////////////////////////////////////////////////////////
  // address decode helpers

  // true when the address hits any implemented register
  function automatic logic addr_mapped(input logic [15:0] a);
    addr_mapped = (a == ADDR_WARN_STATUS) || (a == ADDR_WARN_MODE) ||
                  (a == ADDR_WARN_CLEAR) || (a == ADDR_WARN_DISABLE) ||
                  (a == ADDR_ERR_STATUS);
  endfunction

  // write strobe for one register
  function automatic logic wr_hit(input webank_req_s r, input logic [15:0] a);
    wr_hit = r.wr && (r.addr == a);
  endfunction

  // mode value accepted only in 1..3
  function automatic logic mode_legal(input logic [15:0] m);
    mode_legal = (m == MODE_AUTO) || (m == MODE_STICKY) || (m == MODE_OFF);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // synchronised inputs

  logic [15:0] warn_sync;
  logic [15:0] err_sync;
  logic variant_sync;
  logic [15:0] warn_map;
  logic [15:0] err_map;

  // warning levels cross in from the pins
  webank_sync #(
    .WIDTH(16)
  ) u_warn_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(warn_cond),
    .sync_out(warn_sync)
  );

  // error levels cross in from the pins
  webank_sync #(
    .WIDTH(16)
  ) u_err_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(err_cond),
    .sync_out(err_sync)
  );

  // the variant strap is a pin too, so it gets its own one-bit synchroniser
  webank_sync #(
    .WIDTH(1)
  ) u_strap_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(ctrl_variant),
    .sync_out(variant_sync)
  );

  ////////////////////////////////////////////////////////////////////////////
  // named bit positions

  // each warning source lands on its fixed bit of the mask
  always_comb
  begin
    warn_map = 16'h0000;
    // bits 0 to 7; controller-only sources are masked later by the variant
    warn_map[WB_NO_FLOW_VALVE_OPEN] = warn_sync[WB_NO_FLOW_VALVE_OPEN];
    warn_map[WB_NEG_FLOW] = warn_sync[WB_NEG_FLOW];
    warn_map[WB_SETPOINT_UNREACHED] = warn_sync[WB_SETPOINT_UNREACHED];
    warn_map[WB_PRESSURE_RANGE] = warn_sync[WB_PRESSURE_RANGE];
    warn_map[WB_GAS_TEMP_RANGE] = warn_sync[WB_GAS_TEMP_RANGE];
    warn_map[WB_FLOW_VALVE_CLOSED] = warn_sync[WB_FLOW_VALVE_CLOSED];
    warn_map[WB_WATCHDOG] = warn_sync[WB_WATCHDOG];
    warn_map[WB_UNDERFLOW] = warn_sync[WB_UNDERFLOW];
    // bits 8 to 15
    warn_map[WB_OVERFLOW] = warn_sync[WB_OVERFLOW];
    warn_map[WB_ANALOG_IN_RANGE] = warn_sync[WB_ANALOG_IN_RANGE];
    warn_map[WB_NOT_MEASURING] = warn_sync[WB_NOT_MEASURING];
    warn_map[WB_SETPOINT_HIGH] = warn_sync[WB_SETPOINT_HIGH];
    warn_map[WB_BODY_TEMP_RANGE] = warn_sync[WB_BODY_TEMP_RANGE];
    warn_map[WB_VALVE_OFFLINE] = warn_sync[WB_VALVE_OFFLINE];
    warn_map[WB_GAS_PROPERTIES] = warn_sync[WB_GAS_PROPERTIES];
    warn_map[WB_POWER_UP] = warn_sync[WB_POWER_UP];
  end

  // each error source lands on its fixed bit; the gaps stay zero
  always_comb
  begin
    err_map = 16'h0000;
    err_map[EB_NV_STORAGE] = err_sync[EB_NV_STORAGE];
    err_map[EB_SENSOR_INCOMPAT] = err_sync[EB_SENSOR_INCOMPAT];
    err_map[EB_SENSOR_DAMAGED] = err_sync[EB_SENSOR_DAMAGED];
    err_map[EB_SENSOR_SILENT] = err_sync[EB_SENSOR_SILENT];
    err_map[EB_TEMP_SENSOR] = err_sync[EB_TEMP_SENSOR];
    err_map[EB_ANALOG_IN] = err_sync[EB_ANALOG_IN];
    err_map[EB_ANALOG_OUT] = err_sync[EB_ANALOG_OUT];
    err_map[EB_WIRELESS] = err_sync[EB_WIRELESS];
    // bits 1, 6 and 10 to 15 have no source
  end

  ////////////////////////////////////////////////////////////////////////////
  // register state

  logic [15:0] mode_q;
  logic [15:0] disable_q;
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [15:0] cond_prev_q;
  logic [15:0] err_q;
  logic [15:0] avail;
  logic [15:0] eff_cond;
  logic [15:0] rise;
  logic [15:0] clr_bits;
  logic powerup_q;
  logic led_q;
  webank_rsp_s rsp_q;
  webank_nv_s nv_q;
  // decoded strobes
  logic access;
  logic mode_write;
  logic clear_write;
  logic disable_write;
  // next values
  logic [15:0] sticky_next;
  logic [15:0] rdata_d;
  logic led_d;

  ////////////////////////////////////////////////////////////////////////////
  // register port decode

  // a write and a read in one strobe still count as one access
  assign access = req.wr || req.rd;

  // only a legal value is a mode write at all; the rest is acked and dropped
  assign mode_write = wr_hit(req, ADDR_WARN_MODE) && mode_legal(req.wdata);

  // clear strobes outside sticky mode are dropped here
  assign clear_write = wr_hit(req, ADDR_WARN_CLEAR) && (mode_q == MODE_STICKY);

  // zeros are harmless, so any write to the disable word is taken
  assign disable_write = wr_hit(req, ADDR_WARN_DISABLE);

  ////////////////////////////////////////////////////////////////////////////
  // power-up warning source

  // held for the first cycle after release so bit 15 sees a rising edge
  // a later reset raises it again, just like a power cycle
  always_ff @(posedge clk)
  begin
    if (!resetn)
      powerup_q <= 1'b1;
    else
      powerup_q <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // condition qualification

  // meter variants mask off the controller-only warnings
  always_comb
  begin
    avail = variant_sync ? 16'hFFFF : ~WARN_CTRL_ONLY;
    eff_cond = warn_map & avail & ~disable_q;
    // power-up bit is forced on for the first cycle after release
    eff_cond[WB_POWER_UP] = (warn_map[WB_POWER_UP] | powerup_q)
                            & ~disable_q[WB_POWER_UP];
  end

  // previous condition for edge detection, taken after the synchroniser
  always_ff @(posedge clk)
  begin
    if (!resetn)
      cond_prev_q <= '0;
    else
      cond_prev_q <= eff_cond;
  end

  assign rise = eff_cond & ~cond_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // handling mode register

  // illegal values leave the mode as it stands
  always_ff @(posedge clk)
  begin
    if (!resetn)
      mode_q <= RST_WARN_MODE;
    else if (mode_write)
      mode_q <= req.wdata;
  end

  // a valid write is also handed to nonvolatile storage as a pulse
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      nv_q.valid <= 1'b0;
      nv_q.mode <= RST_WARN_MODE;
    end
    else
    begin
      nv_q.valid <= mode_write;
      if (mode_write)
        nv_q.mode <= req.wdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-warning disable register

  // ones turn reporting off; zeros never re-enable
  always_ff @(posedge clk)
  begin
    if (!resetn)
      disable_q <= RST_WARN_DISABLE;
    else if (disable_write)
      disable_q <= disable_q | req.wdata;
  end

  ////////////////////////////////////////////////////////////////////////////
  // warning status

  // clear bits only count in sticky mode
  assign clr_bits = clear_write ? req.wdata : 16'h0000;

  // sticky keeps what is latched, drops cleared bits, then lets new rises in
  assign sticky_next = (status_q & ~clr_bits) | rise;

  // next status per mode; a rise in the clear cycle wins over the clear
  always_comb
  begin
    status_d = status_q;
    unique case (mode_q)
      MODE_AUTO: status_d = eff_cond;
      MODE_STICKY: status_d = sticky_next;
      MODE_OFF: status_d = 16'h0000;
      default: status_d = 16'h0000;
    endcase
    status_d = status_d & avail & ~disable_q;
  end

  always_ff @(posedge clk)
  begin
    if (!resetn)
      status_q <= RST_WARN_STATUS;
    else
      status_q <= status_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicator

  // taken from the next status, so the indicator never lags the mask
  assign led_d = |status_d;

  // lit whenever any reported bit is set, so it shares the mode handling
  always_ff @(posedge clk)
  begin
    if (!resetn)
      led_q <= 1'b0;
    else
      led_q <= led_d;
  end

  ////////////////////////////////////////////////////////////////////////////
  // error status

  // live copy, only the assigned positions survive
  always_ff @(posedge clk)
  begin
    if (!resetn)
      err_q <= RST_ERR_STATUS;
    else
      err_q <= err_map & ERR_VALID;
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read and answer

  // read mux; only words with a value to show are decoded
  always_comb
  begin
    rdata_d = 16'h0000;
    if (req.rd)
    begin
      // the write-only clear word falls to the default and reads zero
      unique case (req.addr)
        ADDR_WARN_STATUS: rdata_d = status_q;
        ADDR_WARN_MODE: rdata_d = mode_q;
        ADDR_WARN_DISABLE: rdata_d = disable_q;
        ADDR_ERR_STATUS: rdata_d = err_q;
        default: rdata_d = 16'h0000;
      endcase
    end
  end

  // answer one cycle after the strobe; unmapped addresses flag an error
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      rsp_q.ack <= 1'b0;
      rsp_q.err <= 1'b0;
      rsp_q.rdata <= 16'h0000;
    end
    else
    begin
      rsp_q.ack <= access;
      rsp_q.err <= access && !addr_mapped(req.addr);
      rsp_q.rdata <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs

  assign rsp = rsp_q;
  assign nv_save = nv_q;
  assign warn_led = led_q;

endmodule

// ### core/webank_pkg.sv
// Functional notes
// - active warnings readable as 16-bit mask
// - automatic mode: bits follow condition both ways
// - sticky mode: set on rise, hold until cleared
// - off mode: mask and indicator stay cleared
// - mode writes outside 1..3 are ignored
// - valid mode write acts now, saved nonvolatile
// - clear register: ones clear latched warnings
// - clear writes act only in sticky mode
// - warning bits 0..7 fixed positions
// - warning bits 8..15 fixed positions
// - controller-only warnings never set on meters
// - active errors readable as 16-bit mask
// - error bits at fixed positions, others unused
// - disable register: ones turn reporting off
// - disable readback nonzero per disabled warning
package webank_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register map, word addresses of the register port
  localparam logic [15:0] ADDR_WARN_STATUS = 16'h0301;
  localparam logic [15:0] ADDR_WARN_MODE = 16'h0303;
  localparam logic [15:0] ADDR_WARN_CLEAR = 16'h0304;
  localparam logic [15:0] ADDR_WARN_DISABLE = 16'h030A;
  localparam logic [15:0] ADDR_ERR_STATUS = 16'h0321;

  ////////////////////////////////////////////////////////////////////////////
  // handling mode encodings and reset values
  localparam logic [15:0] MODE_AUTO = 16'h0001;
  localparam logic [15:0] MODE_STICKY = 16'h0002;
  localparam logic [15:0] MODE_OFF = 16'h0003;
  localparam logic [15:0] RST_WARN_MODE = 16'h0001;
  localparam logic [15:0] RST_WARN_STATUS = 16'h0000;
  localparam logic [15:0] RST_WARN_DISABLE = 16'h0000;
  localparam logic [15:0] RST_ERR_STATUS = 16'h0000;

  ////////////////////////////////////////////////////////////////////////////
  // warning bit positions
  localparam int WB_NO_FLOW_VALVE_OPEN = 0;
  localparam int WB_NEG_FLOW = 1;
  localparam int WB_SETPOINT_UNREACHED = 2;
  localparam int WB_PRESSURE_RANGE = 3;
  localparam int WB_GAS_TEMP_RANGE = 4;
  localparam int WB_FLOW_VALVE_CLOSED = 5;
  localparam int WB_WATCHDOG = 6;
  localparam int WB_UNDERFLOW = 7;
  localparam int WB_OVERFLOW = 8;
  localparam int WB_ANALOG_IN_RANGE = 9;
  localparam int WB_NOT_MEASURING = 10;
  localparam int WB_SETPOINT_HIGH = 11;
  localparam int WB_BODY_TEMP_RANGE = 12;
  localparam int WB_VALVE_OFFLINE = 13;
  localparam int WB_GAS_PROPERTIES = 14;
  localparam int WB_POWER_UP = 15;

  // warnings that exist only on flow controller variants
  localparam logic [15:0] WARN_CTRL_ONLY = 16'h2A25;

  ////////////////////////////////////////////////////////////////////////////
  // error bit positions; all other bits are unused and read zero
  localparam int EB_NV_STORAGE = 0;
  localparam int EB_SENSOR_INCOMPAT = 2;
  localparam int EB_SENSOR_DAMAGED = 3;
  localparam int EB_SENSOR_SILENT = 4;
  localparam int EB_TEMP_SENSOR = 5;
  localparam int EB_ANALOG_IN = 7;
  localparam int EB_ANALOG_OUT = 8;
  localparam int EB_WIRELESS = 9;
  localparam logic [15:0] ERR_VALID = 16'h03BD;

  ////////////////////////////////////////////////////////////////////////////
  // register port request, one access per strobe
  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } webank_req_s;

  // answer to a register access
  typedef struct packed {
    logic ack;
    logic err;
    logic [15:0] rdata;
  } webank_rsp_s;

  // record handed to nonvolatile storage
  typedef struct packed {
    logic valid;
    logic [15:0] mode;
  } webank_nv_s;

endpackage

// ### core/webank_sync.sv
`timescale 1ns/1ps
// two-flop synchroniser for condition pins
module webank_sync
  import webank_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // asynchronous levels in
  input wire logic [WIDTH-1:0] async_in,
  // synchronised levels out
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  ////////////////////////////////////////////////////////////////////////////
  // first stage is read only by the second stage
  always_ff @(posedge clk)
  begin
    if (!resetn)
    begin
      meta_q <= '0;
      sync_q <= '0;
    end
    else
    begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end

  assign sync_out = sync_q;

endmodule

// ### dv/webank_checker.sv
`timescale 1ns/1ps
// port-level checker for the status bank
module webank_checker
  import webank_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic resetn,
  // register port
  input wire webank_req_s req,
  input wire webank_rsp_s rsp,
  // pins and outputs
  input wire logic [15:0] warn_cond,
  input wire logic [15:0] err_cond,
  input wire logic ctrl_variant,
  input wire logic warn_led,
  input wire webank_nv_s nv_save
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!resetn);
  logic [15:0] mode_q;
  logic [15:0] dis_q;
  logic acc, wr_mode, mode_ok, mapped, rd_stat;
  // request decode
  assign acc = req.wr | req.rd;
  assign wr_mode = req.wr && req.addr == ADDR_WARN_MODE;
  assign mode_ok = req.wdata >= MODE_AUTO && req.wdata <= MODE_OFF;
  assign rd_stat = req.rd && req.addr == ADDR_WARN_STATUS;
  assign mapped = req.addr inside {ADDR_WARN_STATUS, ADDR_WARN_MODE, ADDR_WARN_CLEAR,
    ADDR_WARN_DISABLE, ADDR_ERR_STATUS};
  ////////////////////////////////////////////////////////////////
  // mirror of the mode, so readback can be judged
  always_ff @(posedge clk)
  begin
    if (!resetn)
      mode_q <= MODE_AUTO;
    else if (wr_mode && mode_ok)
      mode_q <= req.wdata;
  end
  // disable only grows, so a mirror stays exact
  always_ff @(posedge clk)
  begin
    if (!resetn)
      dis_q <= 16'h0000;
    else if (req.wr && req.addr == ADDR_WARN_DISABLE)
      dis_q <= dis_q | req.wdata;
  end
  ////////////////////////////////////////////////////////////////
  unmapped_err_a: assert property (acc && !mapped |=> rsp.ack && rsp.err)
    else $error("unmapped access not flagged");
  mode_save_a: assert property (
    wr_mode && mode_ok |=> nv_save.valid && nv_save.mode == $past(req.wdata))
    else $error("legal mode write not saved");
  mode_bad_a: assert property (wr_mode && !mode_ok |=> rsp.ack && !nv_save.valid)
    else $error("illegal mode write saved");
  mode_read_a: assert property (
    req.rd && req.addr == ADDR_WARN_MODE |=> rsp.rdata == $past(mode_q))
    else $error("mode readback wrong");
  off_led_a: assert property ((mode_q == MODE_OFF) [*3] |-> !warn_led)
    else $error("indicator lit in off mode");
  off_read_a: assert property (
    rd_stat && mode_q == MODE_OFF && $past(mode_q) == MODE_OFF |=> rsp.rdata == 16'h0000)
    else $error("status set in off mode");
  meter_mask_a: assert property (
    (!ctrl_variant) [*5] ##0 rd_stat |=> (rsp.rdata & WARN_CTRL_ONLY) == 16'h0000)
    else $error("controller warning on meter");
  disable_mask_a: assert property (
    rd_stat |=> (rsp.rdata & dis_q & $past(dis_q, 2)) == 16'h0000)
    else $error("disabled warning reported");
  led_status_a: assert property (
    rd_stat |=> (rsp.rdata != 16'h0000) == $past(warn_led))
    else $error("indicator disagrees with status");
  err_unused_a: assert property (
    req.rd && req.addr == ADDR_ERR_STATUS |=> (rsp.rdata & ~ERR_VALID) == 16'h0000)
    else $error("unused error bit set");
  // main scenarios
  cover property (wr_mode && req.wdata == MODE_STICKY);
  cover property (req.wr && req.addr == ADDR_WARN_CLEAR && mode_q == MODE_STICKY);
  cover property (acc && !mapped);
endmodule
bind webank_top webank_checker chk (.clk(clk), .resetn(resetn), .req(req), .rsp(rsp),
  .warn_cond(warn_cond), .err_cond(err_cond), .ctrl_variant(ctrl_variant),
  .warn_led(warn_led), .nv_save(nv_save));

// ### dv/tb.sv
`timescale 1ns/1ps
// self-checking bench for the status bank
module tb
  import webank_pkg::*;
;
  logic clk, resetn, ctrl_variant, warn_led;
  logic [15:0] warn_cond, err_cond;
  webank_req_s req;
  webank_rsp_s rsp, r;
  webank_nv_s nv_save, nv;
  int err_total, n_compared;
  webank_top dut (.clk(clk), .resetn(resetn), .req(req), .rsp(rsp), .warn_cond(warn_cond),
    .err_cond(err_cond), .ctrl_variant(ctrl_variant), .warn_led(warn_led), .nv_save(nv_save));
  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  // compare and count
  task chk(string n, logic [15:0] s, logic [15:0] e);
    n_compared++;
    if (s !== e)
    begin
      err_total++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // one access; answer captured in the cycle after it is taken
  task acc(logic w, logic [15:0] a, logic [15:0] d);
    @(posedge clk);
    req <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
    r = rsp;
    nv = nv_save;
  endtask
  task rd(logic [15:0] a, logic [15:0] e, string n);
    acc(1'b0, a, 16'h0000);
    chk(n, r.rdata, e);
    chk("ack", {15'h0000, r.ack}, 16'h0001);
  endtask
  task led(logic e);
    chk("led", {15'h0000, warn_led}, {15'h0000, e});
  endtask
  // pins change, then wait out the synchroniser latency
  task pins(logic [15:0] w, logic [15:0] e);
    @(posedge clk);
    warn_cond <= w;
    err_cond <= e;
    repeat (5) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  task t_reset;
    // taken on the second edge after release, while bit 15 still shows
    rd(ADDR_WARN_STATUS, 16'h8000, "power-up");
    rd(ADDR_WARN_MODE, RST_WARN_MODE, "mode");
    rd(ADDR_WARN_DISABLE, RST_WARN_DISABLE, "disable");
    rd(ADDR_ERR_STATUS, RST_ERR_STATUS, "errors");
    acc(1'b1, ADDR_WARN_STATUS, 16'hFFFF);
    rd(ADDR_WARN_STATUS, RST_WARN_STATUS, "status");
    acc(1'b0, 16'h0302, 16'h0000);
    chk("unmapped", {15'h0000, r.err}, 16'h0001);
  endtask
  // each position alone, auto mode
  task t_auto;
    for (int i = 0; i < 16; i++)
    begin
      pins(16'h0001 << i, 16'h0000);
      led(1'b1);
      rd(ADDR_WARN_STATUS, 16'h0001 << i, "bit");
    end
    acc(1'b1, ADDR_WARN_CLEAR, 16'hFFFF);
    rd(ADDR_WARN_STATUS, 16'h8000, "clear in auto");
    pins(16'h0000, 16'h0000);
    led(1'b0);
    rd(ADDR_WARN_STATUS, 16'h0000, "fall");
  endtask
  task t_mode;
    for (int i = 0; i < 3; i++)
    begin
      acc(1'b1, ADDR_WARN_MODE, 16'(4 * i));
      chk("bad save", {15'h0000, nv.valid}, 16'h0000);
    end
    rd(ADDR_WARN_MODE, MODE_AUTO, "bad mode");
    for (int m = 3; m > 0; m--)
    begin
      acc(1'b1, ADDR_WARN_MODE, 16'(m));
      chk("save", {nv.valid, nv.mode[14:0]}, 16'h8000 | 16'(m));
      rd(ADDR_WARN_MODE, 16'(m), "mode");
    end
  endtask
  task t_sticky;
    acc(1'b1, ADDR_WARN_MODE, MODE_STICKY);
    pins(16'h0018, 16'h0000);
    pins(16'h0000, 16'h0000);
    led(1'b1);
    rd(ADDR_WARN_STATUS, 16'h0018, "held");
    acc(1'b1, ADDR_WARN_CLEAR, 16'h0008);
    rd(ADDR_WARN_STATUS, 16'h0010, "clear one");
    acc(1'b1, ADDR_WARN_CLEAR, 16'h0000);
    rd(ADDR_WARN_STATUS, 16'h0010, "clear zero");
    acc(1'b1, ADDR_WARN_CLEAR, 16'h0010);
    rd(ADDR_WARN_STATUS, 16'h0000, "clear all");
    led(1'b0);
  endtask
  task t_off;
    acc(1'b1, ADDR_WARN_MODE, MODE_OFF);
    pins(16'hFFFF, 16'h0000);
    led(1'b0);
    rd(ADDR_WARN_STATUS, 16'h0000, "off");
    pins(16'h0000, 16'h0000);
    acc(1'b1, ADDR_WARN_MODE, MODE_AUTO);
  endtask
  // meter strap, then errors live
  task t_variant;
    @(posedge clk);
    ctrl_variant <= 1'b0;
    pins(16'hFFFF, 16'hFFFF);
    rd(ADDR_WARN_STATUS, 16'hD5DA, "meter");
    rd(ADDR_ERR_STATUS, 16'h03BD, "err all");
    @(posedge clk);
    ctrl_variant <= 1'b1;
    pins(16'h0000, 16'h0008);
    rd(ADDR_ERR_STATUS, 16'h0008, "err one");
    pins(16'h0000, 16'h0000);
    rd(ADDR_ERR_STATUS, 16'h0000, "err gone");
  endtask
  task t_disable;
    acc(1'b1, ADDR_WARN_DISABLE, 16'h0081);
    acc(1'b1, ADDR_WARN_DISABLE, 16'h0000);
    rd(ADDR_WARN_DISABLE, 16'h0081, "disable");
    pins(16'hFFFF, 16'h0000);
    rd(ADDR_WARN_STATUS, 16'hFF7E, "masked");
    pins(16'h0081, 16'h0000);
    led(1'b0);
  endtask
  ////////////////////////////////////////////////////////////////
  task conclude;
    $display("compared %0d mismatched %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial
  begin
    resetn = 1'b0;
    req = '0;
    warn_cond = 16'h0000;
    err_cond = 16'h0000;
    ctrl_variant = 1'b1;
    err_total = 0;
    n_compared = 0;
    repeat (16) @(posedge clk);
    resetn <= 1'b1;
    t_reset;
    t_auto;
    t_mode;
    t_sticky;
    t_off;
    t_variant;
    t_disable;
    conclude;
  end
  // hang guard, well past the roughly 300 cycles the tests need
  initial
  begin
    #16000;
    err_total++;
    conclude;
  end
endmodule
